/* lrc_core.sv */
// light range and conversion time configuration, with conversion timer and result
// assumes light_level is synchronous to aclk and holds the light in 0.01 lux units
//
// How it works
// - range field bits 15:12 select full scale, coded like the result exponent
// - range code 1100b makes the device pick its own range
// - in automatic mode the chosen range appears in the result exponent
// - range field powers up as the automatic code
// - period bit 0 gives 100 ms conversions, 1 gives 800 ms
// - period bit is read/write and resets to 1
// - long period gives full resolution in every range
// - short period above range 0101b still gives full resolution
// - short period loses 1 bit at 0101b, 2 at 0100b-0001b, 3 at 0000b
// - result format and lsb weight do not depend on period
// - lsb weight is 0.01 lux times two to the range code
// - a config write aborts the running conversion and restarts it
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module lrc_core
    import lrc_pkg::*;
#(
    parameter int unsigned SHORT_CNT = lrc_pkg::SHORT_CYCLES,
    parameter int unsigned LONG_CNT = lrc_pkg::LONG_CYCLES
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [lrc_pkg::LEVEL_W-1:0] light_level,
    output logic integrating,
    output logic conv_done,
    output lrc_pkg::lrc_result_s result,
    output logic [3:0] range_in_use
);
    import lrc_pkg::*;

    // bus state
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic [1:0] next_bresp, next_rresp;
    logic next_bvalid, next_rvalid, next_awready, next_wready, next_arready;
    logic [31:0] next_rdata;
    lrc_cfg_s cfg, next_cfg;
    logic cfg_wr;
    // conversion state
    logic [31:0] cnt, next_cnt;
    logic next_conv_done;
    lrc_result_s next_result;
    logic [3:0] next_range_in_use;
    logic [31:0] target;
    logic [3:0] conv_exp;
    logic [11:0] full_mant, conv_mant;
    logic [1:0] drop;

    // automatic pick: smallest exponent whose shifted level fits 12 bits
    function automatic logic [3:0] auto_exp(input logic [LEVEL_W-1:0] lvl);
        logic [3:0] e;
        e = RANGE_MAX;
        for (int i = 11; i >= 0; i--)
        begin
            if ((lvl >> i) <= LEVEL_W'(MANT_FULL))
                e = 4'(i);
        end
        return e;
    endfunction

    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bresp = s_axi_bresp;
        next_bvalid = s_axi_bvalid;
        next_rresp = s_axi_rresp;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_cfg = cfg;
        cfg_wr = 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        // response taken first, so a response raised in the same cycle is not lost
        if (s_axi_bvalid && s_axi_bready)
            next_bvalid = 1'b0;
        if (aw_held && w_held)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_OKAY;
            if (aw_addr == ADDR_CONFIG)
            begin
                cfg_wr = 1'b1;
                if (w_strb[1])
                begin
                    next_cfg.full_scale_range_select = w_data[RANGE_LSB +: 4];
                    next_cfg.conversion_period_select = w_data[PERIOD_BIT];
                end
            end
            else if (aw_addr != ADDR_RESULT && aw_addr != ADDR_STATUS)
                next_bresp = RESP_SLVERR;
        end
        if (s_axi_rvalid && s_axi_rready)
            next_rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = 32'h0;
            if (s_axi_araddr == ADDR_RESULT)
                next_rdata[15:0] = result;
            else if (s_axi_araddr == ADDR_CONFIG)
            begin
                next_rdata[RANGE_LSB +: 4] = cfg.full_scale_range_select;
                next_rdata[PERIOD_BIT] = cfg.conversion_period_select;
            end
            else if (s_axi_araddr == ADDR_STATUS)
            begin
                next_rdata[STAT_ACTIVE_BIT] = integrating;
                next_rdata[STAT_RANGE_LSB +: 4] = range_in_use;
            end
            else
                next_rresp = RESP_SLVERR;
        end
        // one write in flight: hold off new halves until the response is taken
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_bvalid <= 1'b0;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            cfg.full_scale_range_select <= RANGE_RST;
            cfg.conversion_period_select <= PERIOD_RST;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bresp <= next_bresp;
            s_axi_bvalid <= next_bvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_arready <= next_arready;
            cfg <= next_cfg;
        end
    end

    always_comb
    begin
        target = cfg.conversion_period_select ? LONG_CNT : SHORT_CNT;
        // reserved codes are not expected; they fall back to automatic ranging
        if (cfg.full_scale_range_select >= RANGE_AUTO)
            conv_exp = auto_exp(light_level);
        else
            conv_exp = cfg.full_scale_range_select;
        // weight per lsb doubles with each exponent step
        if ((light_level >> conv_exp) > LEVEL_W'(MANT_FULL))
            full_mant = MANT_FULL;
        else
            full_mant = 12'(light_level >> conv_exp);
        drop = 2'h0;
        if (!cfg.conversion_period_select)
        begin
            if (conv_exp == 4'h0)
                drop = 2'h3;
            else if (conv_exp < RANGE_FULL_RES)
                drop = 2'h2;
            else if (conv_exp == RANGE_FULL_RES)
                drop = 2'h1;
        end
        // the lost low bits read as zero; format and weight stay put
        conv_mant = full_mant & ~((12'h1 << drop) - 12'h1);
        next_cnt = cnt + 32'h1;
        next_conv_done = 1'b0;
        next_result = result;
        next_range_in_use = range_in_use;
        if (cfg_wr)
            next_cnt = 32'h0;
        else if (cnt >= target - 32'h1)
        begin
            next_cnt = 32'h0;
            next_conv_done = 1'b1;
            next_result.exponent = conv_exp;
            next_result.mantissa = conv_mant;
            next_range_in_use = conv_exp;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt <= 32'h0;
            conv_done <= 1'b0;
            result <= '0;
            range_in_use <= 4'h0;
            integrating <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            conv_done <= next_conv_done;
            result <= next_result;
            range_in_use <= next_range_in_use;
            integrating <= 1'b1;
        end
    end

    logic [3:0] exp_d;
    logic [11:0] full_d;
    logic period_d;
    always_ff @(posedge aclk)
    begin
        exp_d <= conv_exp;
        full_d <= full_mant;
        period_d <= cfg.conversion_period_select;
    end

    sequence s_write_cfg;
        aw_held && w_held && aw_addr == ADDR_CONFIG;
    endsequence

    AST_RANGE_RESET: assert property (@(posedge aclk)
        $rose(aresetn) |-> cfg.full_scale_range_select == RANGE_AUTO)
        else $error("range field not automatic after reset");
    AST_PERIOD_RESET: assert property (@(posedge aclk)
        $rose(aresetn) |-> cfg.conversion_period_select == 1'b1)
        else $error("period bit not set after reset");
    AST_ABORT: assert property (@(posedge aclk) disable iff (!aresetn)
        s_write_cfg |=> cnt == 32'h0 && !conv_done)
        else $error("config write did not restart conversion");
    AST_MANUAL_EXP: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_done && $past(cfg.full_scale_range_select) < RANGE_AUTO
        |-> result.exponent == $past(cfg.full_scale_range_select))
        else $error("manual range not used as exponent");
    AST_AUTO_EXP: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_done |-> result.exponent <= RANGE_MAX && range_in_use == result.exponent)
        else $error("reported range out of table");
    AST_LONG_FULL: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_done && period_d |-> result.mantissa == full_d)
        else $error("long period lost resolution");
    AST_SHORT_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_done && !period_d && exp_d > RANGE_FULL_RES |-> result.mantissa == full_d)
        else $error("short period high range lost resolution");
    AST_SHORT_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_done && !period_d && exp_d == 4'h0 |-> result.mantissa[2:0] == 3'h0)
        else $error("range zero short period kept low bits");
    AST_PERIOD_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
        conv_done && !$past(cfg_wr) |-> $past(cnt) == (period_d ? LONG_CNT : SHORT_CNT) - 1)
        else $error("conversion length wrong");
endmodule
`default_nettype wire

/* lrc_pkg.sv */
// constants, carriers and register map for the light range / conversion time block
// assumes a 40 MHz aclk and a 32-bit AXI4-Lite register bus
package lrc_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned T_SHORT_MS = 100;
    localparam int unsigned T_LONG_MS = 800;
    localparam int unsigned SHORT_CYCLES = T_SHORT_MS * (CLK_HZ / 1000);
    localparam int unsigned LONG_CYCLES = T_LONG_MS * (CLK_HZ / 1000);
    // register indices; byte address is four times the index
    localparam int unsigned IDX_RESULT = 0;
    localparam int unsigned IDX_CONFIG = 1;
    localparam int unsigned IDX_STATUS = 2;
    localparam logic [7:0] ADDR_RESULT = 8'(IDX_RESULT * 4);
    localparam logic [7:0] ADDR_CONFIG = 8'(IDX_CONFIG * 4);
    localparam logic [7:0] ADDR_STATUS = 8'(IDX_STATUS * 4);
    // configuration and status field positions
    localparam int unsigned RANGE_LSB = 12;
    localparam int unsigned PERIOD_BIT = 11;
    localparam int unsigned STAT_ACTIVE_BIT = 0;
    localparam int unsigned STAT_RANGE_LSB = 4;
    // codes
    localparam logic [3:0] RANGE_AUTO = 4'hc;
    localparam logic [3:0] RANGE_MAX = 4'hb;
    localparam logic [3:0] RANGE_FULL_RES = 4'h5;
    localparam logic RANGE_RESET = 1'b1;
    localparam logic [3:0] RANGE_RST = RANGE_AUTO;
    localparam logic PERIOD_RST = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int unsigned LEVEL_W = 23;
    localparam logic [11:0] MANT_FULL = 12'hfff;

    typedef struct packed {
        logic [3:0] full_scale_range_select;
        logic conversion_period_select;
    } lrc_cfg_s;

    typedef struct packed {
        logic [3:0] exponent;
        logic [11:0] mantissa;
    } lrc_result_s;

    typedef enum logic [0:0] {
        LRC_IDLE = 1'b0,
        LRC_RESP = 1'b1
    } lrc_bus_e;
endpackage

/* lrc_host.sv */
// host model: AXI4-Lite master with blocking one-word access tasks
// assumes it shares aclk with the slave and tasks are entered just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module lrc_host
(
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // response readies stay high, so no release can collide with the next request
    initial
    begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} <= '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_wstrb} <= '0;
        s_axi_bready <= 1'b1;
        s_axi_rready <= 1'b1;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
endmodule
`default_nettype wire

/* light_range_conv_time_config_tb.sv */
// testbench: range and conversion period programming, result format, conversion timing
// assumes lrc_core with shortened conversion counts and lrc_host as bus master
`timescale 1ns/1ps
`default_nettype none
module light_range_conv_time_config_tb;
    import lrc_pkg::*;
    localparam int SC = 20;
    localparam int LC = 50;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb, range_in_use;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic integrating, conv_done;
    lrc_result_s result;
    logic [LEVEL_W-1:0] light_level = '0;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    int n;

    always #12.5 aclk = ~aclk;

    lrc_core #(.SHORT_CNT(SC), .LONG_CNT(LC)) lrc_core_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .light_level(light_level),
        .integrating(integrating), .conv_done(conv_done),
        .result(result), .range_in_use(range_in_use)
    );
    lrc_host lrc_host_i (
        .aclk(aclk),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready)
    );

    task automatic summarize();
        if (failures == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %0t %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask

    // independent model of range choice, saturation and short-period bit loss
    function automatic logic [15:0] expv(input logic [3:0] c, input logic p,
                                         input logic [22:0] lv);
        logic [3:0] e;
        logic [22:0] s;
        int k;
        e = c;
        if (c >= 4'hc)
        begin
            e = 4'hb;
            for (int i = 11; i >= 0; i--)
                if ((lv >> i) <= 23'hfff) e = 4'(i);
        end
        s = lv >> e;
        if (s > 23'hfff) s = 23'hfff;
        k = (!p && e <= 4'h5) ? ((e == 4'h0) ? 3 : (e == 4'h5) ? 1 : 2) : 0;
        s = (s >> k) << k;
        return {e, s[11:0]};
    endfunction

    task automatic wait_done();
        do @(posedge aclk); while (conv_done !== 1'b1);
    endtask

    // only codes 0..c are ever written
    task automatic run(input logic [3:0] c, input logic p, input logic [22:0] lv);
        light_level <= lv;
        lrc_host_i.wr(ADDR_CONFIG, {16'h0, c, p, 11'h0}, r);
        chk(r, RESP_OKAY, "write resp");
        lrc_host_i.rd(ADDR_CONFIG, d, r);
        chk(d, {16'h0, c, p, 11'h0}, "config readback");
        wait_done();
        chk(result, expv(c, p, lv), "result");
        chk(range_in_use, expv(c, p, lv) >> 12, "range in use");
        lrc_host_i.rd(ADDR_RESULT, d, r);
        chk(d, expv(c, p, lv), "result read");
    endtask

    task automatic period(input logic p, input int exp);
        lrc_host_i.wr(ADDR_CONFIG, {16'h0, 4'hc, p, 11'h0}, r);
        wait_done();
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end while (conv_done !== 1'b1);
        chk(n, exp, "conversion length");
    endtask

    always @(posedge aclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            failures++;
            summarize();
        end
    end

    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        lrc_host_i.rd(ADDR_CONFIG, d, r);
        chk(d, 32'h0000c800, "reset config");
        period(1'b1, LC);
        period(1'b0, SC);
        run(4'h0, 1'b0, 23'h000fff);
        run(4'h3, 1'b0, 23'h002357);
        run(4'h5, 1'b0, 23'h012365);
        run(4'h6, 1'b0, 23'h012365);
        run(4'h0, 1'b1, 23'h000abc);
        run(4'h1, 1'b1, 23'h7fffff);
        run(4'hb, 1'b1, 23'h7fffff);
        run(4'hc, 1'b1, 23'h012345);
        run(4'hc, 1'b0, 23'h000007);
        run(4'hc, 1'b1, 23'h7fffff);
        // mid-conversion rewrite must restart the long count
        wait_done();
        repeat (30) @(posedge aclk);
        lrc_host_i.wr(ADDR_CONFIG, 32'h0000c800, r);
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end while (conv_done !== 1'b1);
        chk(n > 40 && n <= LC, 1'b1, "abort restart");
        // last conversion ran automatic at full scale light: range 0xb, timer running
        lrc_host_i.rd(ADDR_STATUS, d, r);
        chk(d, {24'h0, 4'hb, 3'h0, 1'b1}, "status read");
        chk(integrating, 1'b1, "integrating");
        lrc_host_i.rd(8'h40, d, r);
        chk(d, 32'h0, "unmapped read data");
        chk(r, RESP_SLVERR, "unmapped read resp");
        lrc_host_i.wr(8'h40, 32'h0, r);
        chk(r, RESP_SLVERR, "unmapped write");
        summarize();
    end
endmodule
`default_nettype wire
